// ===== src/fwsc_pkg.sv
// Shared constants, types and helpers for the filter wheel and shutter control
package fwsc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLOCK_MHZ       = 250;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int CYCLES_PER_MS   = CLOCK_MHZ * 1000;
  localparam int HOME_TIMEOUT_MS = 4000;

  // ==========================================================================
  // Wheel positions, speeds and selectors
  localparam logic [3:0] HOME_POS       = 4'h0;
  localparam logic [3:0] AWAY_POS       = 4'h9;
  localparam logic [3:0] LAST_POS_SHORT = 4'h3;
  localparam logic [3:0] WRAP_TEN       = 4'hA;
  localparam logic [3:0] WRAP_SHORT     = 4'h4;
  localparam logic [2:0] HOME_SPEED     = 3'h7;
  localparam logic [2:0] RESET_SPEED    = 3'h1;
  localparam logic [2:0] HOME_HOPS      = 3'h1;
  localparam logic [1:0] WHEEL_A        = 2'h0;
  localparam logic [1:0] WHEEL_B        = 2'h1;
  localparam logic [1:0] WHEEL_C        = 2'h2;

  // Wheel class codes as reported by the wheel identity pins
  localparam logic [1:0] CLASS_STD10    = 2'h0;
  localparam logic [1:0] CLASS_FAST4    = 2'h1;
  localparam logic [1:0] CLASS_STRONG10 = 2'h2;

  // Remote interface codes
  localparam logic [1:0] PORT_USB       = 2'h0;
  localparam logic [1:0] PORT_SERIAL    = 2'h1;
  localparam logic [1:0] PORT_PARALLEL  = 2'h2;

  // Keypad codes: 0 to 9 are digits
  localparam logic [3:0] KEY_LAST_DIGIT = 4'h9;
  localparam logic [3:0] KEY_LOCAL      = 4'hA;
  localparam logic [3:0] KEY_MODE       = 4'hB;
  localparam logic [3:0] KEY_SHUTTER_A  = 4'hC;
  localparam logic [3:0] KEY_SHUTTER_B  = 4'hD;
  localparam logic [3:0] KEY_EXIT       = 4'h0;
  localparam logic [3:0] KEY_ONE        = 4'h1;
  localparam logic [3:0] KEY_TWO        = 4'h2;
  localparam logic [3:0] KEY_THREE      = 4'h3;
  localparam logic [3:0] KEY_FOUR       = 4'h4;
  localparam logic [3:0] KEY_LAST_SPEED = 4'h7;

  // External shutter input modes
  localparam logic [1:0] TTL_OFF_MODE   = 2'h0;
  localparam logic [1:0] TTL_OPEN_HIGH  = 2'h1;
  localparam logic [1:0] TTL_OPEN_LOW   = 2'h2;
  localparam logic [1:0] TTL_TOGGLE     = 2'h3;

  // ==========================================================================
  // Move durations in ms, rows speed 0..7, columns 1..5 positions
  // 31 51 74 95 115 / 40 65 95 120 148 / ... / 230 440 650 860 1100
  localparam logic [10:0] MOVE_MS [0:7][0:4] = '{
    '{11'h01F, 11'h033, 11'h04A, 11'h05F, 11'h073},
    '{11'h028, 11'h041, 11'h05F, 11'h078, 11'h094},
    '{11'h02C, 11'h04B, 11'h069, 11'h088, 11'h0A8},
    '{11'h032, 11'h058, 11'h07F, 11'h0A5, 11'h0CD},
    '{11'h03C, 11'h06C, 11'h09C, 11'h0CD, 11'h0FA},
    '{11'h044, 11'h07B, 11'h0B2, 11'h0EB, 11'h122},
    '{11'h07C, 11'h0EB, 11'h15E, 11'h1CC, 11'h244},
    '{11'h0E6, 11'h1B8, 11'h28A, 11'h35C, 11'h44C}};

  // ==========================================================================
  // Types
  typedef enum {ST_SEEK, ST_AWAY, ST_CHECK, ST_BACK, ST_ERROR, ST_IDLE,
                ST_MOVE} fwsc_state_t;
  typedef enum {MN_NONE, MN_TOP, MN_WHEEL, MN_SPEED, MN_TTL,
                MN_TTL_MODE} fwsc_menu_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] mode;
  } fwsc_ttl_cfg_t;

  typedef struct packed {
    logic usb;
    logic serial;
    logic parallel;
    logic local_mode;
  } fwsc_flags_t;

  typedef struct packed {
    logic       run;
    logic       forward;
    logic       slow;
    logic [1:0] wheel;
  } fwsc_motor_t;

  // ==========================================================================
  // Helpers
  function automatic logic [10:0] move_ms(input logic [2:0] speed,
                                          input logic [2:0] hops);
    logic [2:0] col;
    col = hops - 3'h1;
    return MOVE_MS[speed][col];
  endfunction

  // Positions travelled going forward, modulo the wheel size
  function automatic logic [3:0] fwd_hops(input logic [3:0] from,
                                          input logic [3:0] to,
                                          input logic [3:0] wrap);
    logic [4:0] sum;
    sum = {1'b0, to} + {1'b0, wrap} - {1'b0, from};
    return (to >= from) ? (to - from) : sum[3:0];
  endfunction

endpackage

// ===== src/fwsc_sync.sv
// Two-stage pin synchroniser with edge detection on the settled value
`timescale 1ns/10ps
module fwsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  // ==========================================================================
  // Synchroniser
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] prev;

  // Only stage2 reads stage1, so a metastable sample never reaches logic
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
      prev   <= '0;
    end
    else if (clk_en)
    begin
      stage1 <= srst ? '0 : pin_in;
      stage2 <= srst ? '0 : stage1;
      prev   <= srst ? '0 : stage2;
    end
  end

  // Edges are taken from the settled copy only
  assign level = stage2;
  assign rise  = stage2 & ~prev;
  assign fall  = prev & ~stage2;

endmodule // fwsc_sync

// ===== src/fwsc_move_timer.sv
// Millisecond tick and move duration timer for wheel moves
`timescale 1ns/10ps
module fwsc_move_timer
  import fwsc_pkg::*;
#(
  parameter int TICK_CYCLES = fwsc_pkg::CYCLES_PER_MS
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic [2:0] speed,
  input  wire logic [2:0] hops,
  output logic            busy,
  output logic            done,
  output logic            ms_tick
);

  // ==========================================================================
  // Tick divider and countdown
  logic [17:0] div;
  logic [10:0] remain;
  wire         div_end = (div == 18'(TICK_CYCLES - 1));

  // Free-running tick: the first ms of a move may be short by under 1 ms
  assign ms_tick = div_end;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div    <= 18'h00000;
      remain <= 11'h000;
      busy   <= 1'b0;
      done   <= 1'b0;
    end
    else if (clk_en)
    begin
      div  <= (srst || div_end) ? 18'h00000 : div + 18'h00001;
      done <= !srst && busy && ms_tick && (remain == 11'h001);
      if (srst)
      begin
        busy   <= 1'b0;
        remain <= 11'h000;
      end
      else if (start)
      begin
        busy   <= 1'b1;
        remain <= move_ms(speed, hops); // see R17
      end
      else if (busy && ms_tick)
      begin
        busy   <= (remain != 11'h001);
        remain <= remain - 11'h001;
      end
    end
  end

endmodule // fwsc_move_timer

// ===== src/fwsc_top.sv
// Filter wheel homing, keypad, wheel moves and shutter control
//
// Notes on behaviour
// R1 - Power-up: turn wheel slowly until home seen
// R2 - After home: step away, then return home
// R3 - Home not confirmed during power-up flags error
// R4 - Non-ten wheel accepts positions 0 to 3
// R5 - Wheel class taken from identity pins automatically
// R6 - After init show USB flag, serial when activated
// R7 - Local key enters local mode, shows local flag
// R8 - Stored setting picks power-on remote interface
// R9 - Local digit moves active wheel, reports position
// R10 - Keys sampled while held, act on release
// R11 - Pressed during move, released after: normal key
// R12 - Pressed and released during move: discarded
// R13 - Shutter keys toggle shutters A and B
// R14 - Wheel A active at power-on; menu selects wheel
// R15 - Eight speeds, 0 fastest, 7 slowest
// R16 - Always take the shorter direction
// R17 - Duration from speed and positions travelled
// R18 - Fastest speed only with four-position wheel; the speed menu accepts speed 0 on any wheel
// R19 - Per-shutter external input enable via menu
// R20 - Open-on-high follows input level
// R21 - Open-on-low follows inverted input level
// R22 - Toggle mode flips shutter on rising edge
// R23 - Inputs synchronised; synchronous clear resets state; port pins are not synchronised
`timescale 1ns/10ps
module fwsc_top #(
  parameter int MS_TICK_CYCLES = fwsc_pkg::CYCLES_PER_MS
) (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire logic                  srst,
  input  wire logic                  home_sensor,
  input  wire logic                  ten_pos_sensor,
  input  wire logic [1:0]            wheel_id,
  input  wire logic                  key_down,
  input  wire logic [3:0]            key_code,
  input  wire logic [1:0]            shutter_ttl,
  input  wire logic [1:0]            default_port,
  input  wire logic                  serial_select,
  input  wire logic                  remote_request,
  output fwsc_pkg::fwsc_motor_t      motor,
  output fwsc_pkg::fwsc_flags_t      flags,
  output logic [3:0]                 position,
  output logic [2:0]                 speed,
  output logic [1:0]                 wheel_class,
  output logic                       ten_wheel,
  output logic                       init_done,
  output logic                       home_error,
  output logic                       moving,
  output logic                       shutter_a_open,
  output logic                       shutter_b_open
);
  import fwsc_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [1:0] ttl_level;
  logic [1:0] ttl_rise;
  logic [8:0] pin_level;
  logic [8:0] pin_rise_nc;
  logic [8:0] pin_fall;

  // Sensor, identity, keypad and shutter pins settle through two flops before any decode; port pins do not (see R23)
  fwsc_sync #(.WIDTH(2)) u_ttl_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .srst   (srst),
    .pin_in (shutter_ttl),
    .level  (ttl_level),
    .rise   (ttl_rise),
    .fall   ()
  );

  fwsc_sync #(.WIDTH(9)) u_pin_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .srst   (srst),
    .pin_in ({home_sensor, ten_pos_sensor, wheel_id, key_down, key_code}),
    .level  (pin_level),
    .rise   (pin_rise_nc),
    .fall   (pin_fall)
  );

  wire       home_s   = pin_level[8];
  wire       tenpos_s = pin_level[7];
  wire [1:0] id_s     = pin_level[6:5];
  wire       key_s    = pin_level[4];
  wire [3:0] code_s   = pin_level[3:0];
  wire       key_rel  = pin_fall[4];

  // ==========================================================================
  // State
  fwsc_state_t   state;
  fwsc_menu_t    menu;
  fwsc_ttl_cfg_t ttl_cfg [0:1];
  logic [3:0]    wheel_pos [0:2];
  logic [2:0]    wheel_speed [0:2];
  logic [1:0]    wheel_sel;
  logic [3:0]    key_held;
  logic          key_in_move;
  logic          ttl_sel;
  logic [3:0]    move_target;
  logic          move_fwd;
  logic [11:0]   seek_ms;
  logic          local_mode;
  logic [1:0]    active_port;
  logic          port_loaded;
  logic          sh_open [0:1];

  logic          timer_busy;
  logic          timer_done;
  logic          ms_tick;

  // ==========================================================================
  // Key decode
  // Code is latched while the key is held; the action waits for release
  wire key_fire  = key_rel && !(key_in_move && moving); // see R10 R11 R12
  wire cmd_ok    = key_fire && (state == ST_IDLE) && local_mode;
  wire key_digit = (key_held <= KEY_LAST_DIGIT);
  wire menu_idle = (menu == MN_NONE);

  // ==========================================================================
  // Move planning for the active wheel
  wire [3:0] wrap      = ten_wheel ? WRAP_TEN : WRAP_SHORT;
  wire [3:0] half      = wrap >> 1;
  wire [3:0] cur_pos   = wheel_pos[wheel_sel];
  wire [3:0] hops_fwd  = fwd_hops(cur_pos, key_held, wrap);
  wire       plan_fwd  = (hops_fwd <= half); // see R16
  wire [3:0] plan_hops = plan_fwd ? hops_fwd : (wrap - hops_fwd);
  wire       pos_legal = ten_wheel || (key_held <= LAST_POS_SHORT); // see R4
  wire       move_go   = cmd_ok && menu_idle && key_digit && pos_legal &&
                         (key_held != cur_pos); // see R9

  // Timer feed: homing steps run one position at the slow speed
  wire       homing     = (state == ST_SEEK) || (state == ST_CHECK);
  wire       start_home = ((state == ST_SEEK) && home_s) ||
                          (state == ST_CHECK);
  wire       timer_go   = start_home || move_go;
  wire [2:0] timer_spd  = homing ? HOME_SPEED : wheel_speed[wheel_sel];
  wire [2:0] timer_hops = homing ? HOME_HOPS : plan_hops[2:0];
  wire       seek_out   = (seek_ms == 12'(HOME_TIMEOUT_MS));

  fwsc_move_timer #(.TICK_CYCLES(MS_TICK_CYCLES)) u_timer (
    .clock   (clock),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .srst    (srst),
    .start   (timer_go),
    .speed   (timer_spd),
    .hops    (timer_hops),
    .busy    (timer_busy),
    .done    (timer_done),
    .ms_tick (ms_tick)
  );

  // ==========================================================================
  // Motor drive decode
  fwsc_motor_t next_motor;
  assign next_motor.run     = (state == ST_SEEK) || timer_busy;
  assign next_motor.forward = (state == ST_AWAY) ? 1'b0 :
                              (state == ST_MOVE) ? move_fwd : 1'b1;
  assign next_motor.slow    = (state != ST_MOVE); // see R1
  assign next_motor.wheel   = (state == ST_MOVE) ? wheel_sel : WHEEL_A;

  // ==========================================================================
  // Sequencer: power-up homing, then local moves
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state       <= ST_SEEK;
      seek_ms     <= 12'h000;
      move_target <= HOME_POS;
      move_fwd    <= 1'b1;
      ten_wheel   <= 1'b1;
      wheel_class <= CLASS_STD10;
      wheel_pos   <= '{HOME_POS, HOME_POS, HOME_POS};
    end
    else if (clk_en)
    begin
      if (srst)
      begin
        state     <= ST_SEEK;
        seek_ms   <= 12'h000;
        ten_wheel <= 1'b1;
        wheel_pos <= '{HOME_POS, HOME_POS, HOME_POS};
      end
      else
      begin
        case (state)
          ST_SEEK:
          begin
            seek_ms <= ms_tick ? seek_ms + 12'h001 : seek_ms;
            if (home_s)
              state <= ST_AWAY; // see R1 R2
            else if (seek_out)
              state <= ST_ERROR; // see R3
          end
          ST_AWAY:
            if (timer_done)
              state <= ST_CHECK; // see R2
          ST_CHECK:
          begin
            ten_wheel   <= tenpos_s; // see R4
            wheel_class <= id_s; // see R5
            state       <= ST_BACK;
          end
          ST_BACK:
            if (timer_done)
              state <= home_s ? ST_IDLE : ST_ERROR; // see R2 R3
          ST_IDLE:
            if (move_go)
            begin
              state       <= ST_MOVE;
              move_target <= key_held;
              move_fwd    <= plan_fwd;
            end
          ST_MOVE:
            if (timer_done)
            begin
              state                <= ST_IDLE;
              wheel_pos[wheel_sel] <= move_target; // see R9
            end
          ST_ERROR:
            state <= ST_ERROR;
          default:
            state <= ST_SEEK;
        endcase
      end
    end
  end

  // ==========================================================================
  // Keypad latch: code and whether the press began during a move
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_held    <= 4'h0;
      key_in_move <= 1'b0;
    end
    else if (clk_en)
    begin
      if (srst)
      begin
        key_held    <= 4'h0;
        key_in_move <= 1'b0;
      end
      else if (key_s && !key_rel && pin_rise_nc[4])
      begin
        key_held    <= code_s; // see R10
        key_in_move <= moving; // see R12
      end
    end
  end

  // ==========================================================================
  // Menu walk: wheel select, speed and external input setup
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      menu        <= MN_NONE;
      wheel_sel   <= WHEEL_A;
      ttl_sel     <= 1'b0;
      wheel_speed <= '{RESET_SPEED, RESET_SPEED, RESET_SPEED};
      ttl_cfg     <= '{'{1'b0, TTL_OFF_MODE}, '{1'b0, TTL_OFF_MODE}};
    end
    else if (clk_en)
    begin
      if (srst)
      begin
        menu        <= MN_NONE;
        wheel_sel   <= WHEEL_A; // see R14
        wheel_speed <= '{RESET_SPEED, RESET_SPEED, RESET_SPEED};
        ttl_cfg     <= '{'{1'b0, TTL_OFF_MODE}, '{1'b0, TTL_OFF_MODE}};
      end
      else if (cmd_ok)
      begin
        // Speed 0 is a value here, so exit on 0 is skipped in that menu
        if (key_held == KEY_MODE)
          menu <= MN_TOP;
        else if (menu == MN_SPEED && key_held <= KEY_LAST_SPEED)
        begin
          wheel_speed[wheel_sel] <= key_held[2:0]; // see R15
          menu <= MN_NONE;
        end
        else if (key_held == KEY_EXIT || !key_digit)
          menu <= menu_idle ? MN_NONE : (key_digit ? MN_NONE : menu);
        else
        begin
          case (menu)
            MN_TOP:
              menu <= (key_held == KEY_ONE)   ? MN_WHEEL :
                      (key_held == KEY_TWO)   ? MN_SPEED :
                      (key_held == KEY_THREE) ? MN_TTL : MN_NONE;
            MN_WHEEL:
            begin
              if (key_held <= KEY_THREE)
                wheel_sel <= 2'(key_held - KEY_ONE); // see R14
              menu <= MN_NONE;
            end
            MN_TTL:
            begin
              ttl_sel <= (key_held >= KEY_THREE);
              if (key_held <= KEY_FOUR)
                ttl_cfg[key_held >= KEY_THREE].enable <=
                  key_held[0]; // see R19
              menu <= (key_held[0] && key_held <= KEY_THREE) ?
                      MN_TTL_MODE : MN_NONE;
            end
            MN_TTL_MODE:
            begin
              if (key_held <= KEY_THREE)
                ttl_cfg[ttl_sel].mode <= key_held[1:0];
              menu <= MN_NONE;
            end
            MN_NONE:
              menu <= MN_NONE;
            default:
              menu <= MN_NONE;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Shutter state update, shared by both shutters
  function automatic logic shutter_next(input logic          open_now,
                                        input fwsc_ttl_cfg_t cfg,
                                        input logic          lvl,
                                        input logic          edge_up,
                                        input logic          key_hit);
    logic follow;
    follow = cfg.enable && (cfg.mode != TTL_TOGGLE) &&
             (cfg.mode != TTL_OFF_MODE);
    if (follow)
      return (cfg.mode == TTL_OPEN_HIGH) ? lvl : !lvl; // see R20 R21
    return open_now ^ key_hit ^
           (cfg.enable && cfg.mode == TTL_TOGGLE && edge_up); // see R22
  endfunction

  wire key_sh_a = cmd_ok && menu_idle && (key_held == KEY_SHUTTER_A);
  wire key_sh_b = cmd_ok && menu_idle && (key_held == KEY_SHUTTER_B);

  // Level modes override the key toggle while they are selected
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      sh_open <= '{1'b0, 1'b0};
    else if (clk_en)
    begin
      sh_open[0] <= !srst && shutter_next(sh_open[0], ttl_cfg[0],
                      ttl_level[0], ttl_rise[0], key_sh_a); // see R13
      sh_open[1] <= !srst && shutter_next(sh_open[1], ttl_cfg[1],
                      ttl_level[1], ttl_rise[1], key_sh_b); // see R13
    end
  end

  // ==========================================================================
  // Remote interface and local mode
  // Power-on port is captured on the first enabled cycle after release
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      local_mode  <= 1'b0;
      active_port <= PORT_USB;
      port_loaded <= 1'b0;
    end
    else if (clk_en)
    begin
      port_loaded <= !srst;
      if (srst || !port_loaded)
        active_port <= default_port; // see R8
      else if (serial_select)
        active_port <= PORT_SERIAL; // see R6
      if (srst || remote_request)
        local_mode <= 1'b0;
      else if (key_fire && state == ST_IDLE && key_held == KEY_LOCAL)
        local_mode <= 1'b1; // see R7
    end
  end

  // ==========================================================================
  // Registered outputs
  fwsc_flags_t next_flags;
  assign next_flags.local_mode = local_mode;
  assign next_flags.usb      = !local_mode && (active_port == PORT_USB);
  assign next_flags.serial   = !local_mode && (active_port == PORT_SERIAL);
  assign next_flags.parallel = !local_mode && (active_port == PORT_PARALLEL);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      motor          <= '0;
      flags          <= '0;
      position       <= HOME_POS;
      speed          <= RESET_SPEED;
      init_done      <= 1'b0;
      home_error     <= 1'b0;
      moving         <= 1'b0;
      shutter_a_open <= 1'b0;
      shutter_b_open <= 1'b0;
    end
    else if (clk_en)
    begin
      motor          <= next_motor;
      flags          <= (state == ST_IDLE || state == ST_MOVE) ?
                        next_flags : '0; // see R6 R7
      position       <= cur_pos; // see R9
      speed          <= wheel_speed[wheel_sel];
      init_done      <= (state == ST_IDLE) || (state == ST_MOVE);
      home_error     <= (state == ST_ERROR); // see R3
      moving         <= (state == ST_MOVE) && !timer_done;
      shutter_a_open <= sh_open[0];
      shutter_b_open <= sh_open[1];
    end
  end

endmodule // fwsc_top

// ===== dv/fwsc_monitor.sv
// Port checker for the filter wheel controller, with its bind
`timescale 1ns/10ps
module fwsc_monitor (
  input wire logic                  clock,
  input wire logic                  arst_n,
  input wire logic                  srst,
  input wire fwsc_pkg::fwsc_motor_t motor,
  input wire fwsc_pkg::fwsc_flags_t flags,
  input wire logic [3:0]            position,
  input wire logic                  ten_wheel,
  input wire logic                  init_done,
  input wire logic                  home_error,
  input wire logic                  moving
);
  import fwsc_pkg::*;
  // ====================================
  // Checks, silent while either reset holds
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n || srst);
  a_slow_homing: assert property (
    !init_done && motor.run |-> motor.slow) else $error("fast homing");
  a_home_first: assert property (
    $rose(init_done) |-> position == HOME_POS) else $error("not home");
  a_error_excl: assert property (
    home_error |-> !init_done) else $error("error and ready");
  a_error_sticky: assert property (
    home_error |=> home_error || $past(srst, 2)) else $error("error dropped");
  a_short_wheel: assert property (
    init_done && !ten_wheel |-> position <= LAST_POS_SHORT)
    else $error("position past short wheel");
  a_flags_init: assert property (
    !init_done |-> flags == '0) else $error("flags before init");
  a_local_hides: assert property (
    flags.local_mode |-> !(flags.usb || flags.serial || flags.parallel))
    else $error("remote flag in local mode");
  a_move_len: assert property (
    $rose(moving) |-> moving[*8]) else $error("move too short");
  // Main scenarios reached
  cover property ($rose(moving));
  cover property ($rose(home_error));
  cover property (flags.local_mode && init_done);
endmodule // fwsc_monitor

bind fwsc_top fwsc_monitor u_mon (.clock, .arst_n, .srst, .motor, .flags,
  .position, .ten_wheel, .init_done, .home_error, .moving);

// ===== dv/fwsc_wheel_model.sv
// Wheel mechanics model driving the home sensor
`timescale 1ns/10ps
module fwsc_wheel_model (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire fwsc_pkg::fwsc_motor_t motor,
  input  wire logic                  stuck,
  output logic                       home_sensor
);
  import fwsc_pkg::*;
  logic [4:0] steps;
  // ====================================
  // Home seen after 20 forward run cycles, lost on any reverse run
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      steps <= 5'h00;
    else if (motor.run && !motor.forward)
      steps <= 5'h00;
    else if (motor.run && steps != 5'h14)
      steps <= steps + 5'h01;
  // A dead sensor never reports home, forcing the error path
  assign home_sensor = (steps == 5'h14) && !stuck;
endmodule // fwsc_wheel_model

// ===== dv/fwsc_top_test.sv
// Self-checking bench for the filter wheel controller
`timescale 1ns/10ps
module fwsc_top_test;
  import fwsc_pkg::*;
  logic clock = 0, arst_n = 0, srst = 0, key_down = 0, stuck = 0, ten = 1;
  logic [3:0] key_code = 4'h0;
  logic [1:0] shutter_ttl = 2'h0;
  logic home_sensor, ten_wheel, init_done, home_error, moving, sh_a, sh_b;
  fwsc_motor_t motor;
  fwsc_flags_t flags;
  logic [3:0] position;
  logic [2:0] speed;
  logic [1:0] wheel_class;
  int n_fail = 0, checked = 0, cyc = 0, t0;
  // ====================================
  // Clock, design and wheel; short ms tick keeps the run brief
  always #2 clock = ~clock;
  fwsc_top #(.MS_TICK_CYCLES(4)) u_dut (.clock, .arst_n, .clk_en(1'b1),
    .srst, .home_sensor, .ten_pos_sensor(ten), .wheel_id(CLASS_STRONG10),
    .key_down, .key_code, .shutter_ttl, .default_port(PORT_USB),
    .serial_select(1'b0), .remote_request(1'b0), .motor, .flags,
    .position, .speed, .wheel_class, .ten_wheel, .init_done, .home_error,
    .moving, .shutter_a_open(sh_a), .shutter_b_open(sh_b));
  fwsc_wheel_model u_wheel (.clock, .arst_n, .motor, .stuck, .home_sensor);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  // Code held steady around the whole press, action comes on release
  task key(input logic [3:0] c);
    @(posedge clock) key_code <= c;
    @(posedge clock) key_down <= 1'b1;
    repeat (6) @(posedge clock);
    key_down <= 1'b0;
    repeat (9) @(posedge clock);
  endtask
  task t_home;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    wait (init_done === 1'b1);
    @(posedge clock);
    chk(position, 0);
    chk(flags, 4'b1000);
    chk(wheel_class, CLASS_STRONG10);
    chk(speed, 1);
    $display("homing test done");
  endtask
  task t_move;
    key(KEY_LOCAL);
    chk(flags, 4'b0001);
    key(4'h7); // digit 7 starts a reverse move to position 7 at speed 1
    t0 = cyc;
    chk({moving, motor.forward}, 2'b10);
    key(4'h4);
    wait (moving === 1'b0);
    chk((cyc - t0) inside {[366:382]}, 1);
    repeat (20) @(posedge clock);
    chk(position, 7);
    chk(moving, 0);
    $display("move test done");
  endtask
  task t_shut;
    key(KEY_SHUTTER_A);
    key(KEY_SHUTTER_B);
    chk({sh_a, sh_b}, 2'b11);
    key(KEY_MODE);
    key(KEY_THREE);
    key(KEY_ONE);
    key(KEY_ONE);
    chk(sh_a, 0);
    shutter_ttl <= 2'b01;
    repeat (6) @(posedge clock);
    chk(sh_a, 1);
    key(KEY_MODE);
    key(KEY_THREE);
    key(KEY_THREE);
    key(KEY_THREE);
    shutter_ttl <= 2'b11;
    repeat (6) @(posedge clock);
    chk(sh_b, 0);
    key(KEY_MODE);
    key(KEY_THREE);
    key(KEY_ONE);
    key(KEY_TWO);
    chk(sh_a, 0);
    shutter_ttl <= 2'b10;
    repeat (6) @(posedge clock);
    chk(sh_a, 1);
    $display("shutter test done");
  endtask
  // Dead sensor: re-home must time out into the error state
  task t_err;
    stuck <= 1'b1;
    srst <= 1'b1;
    @(posedge clock) srst <= 1'b0;
    wait (home_error === 1'b1);
    chk(init_done, 0);
    $display("error test done");
  endtask
  task close_out;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard sized well past the longest homing timeout
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      close_out;
    end
  end
  initial
  begin
    t_home;
    t_move;
    t_shut;
    t_err;
    close_out;
  end
endmodule // fwsc_top_test
